// [core/erc_checker.v]
// Extent reservation checker with an APB register port.
//
// Functional notes
// - descriptor byte0 relflag b2, type b1:0
// - type 00 rdshr,01 wrexcl,10 rdexcl,11 excl
// - read exclusive blocks others' reads and copies
// - write exclusive blocks others' writes and copies
// - exclusive access blocks all other access
// - read shared blocks every write, holder too
// - relative flag adds signed offset to last
// - relative needs linked prior access, else illegal
// - forbidden access returns reservation conflict
// - any blocked part blocks whole command
// - blocked copy gives data protect check
// - format refused while any extent reserved
// - third party flag grants to named device
// - third party kept until supersede/release/reset
// - foreign release of third party ignored
// - third party copies requester parameter set
// - granted reserve with same id discards maker's old
// - superseding keeps existing reservation identifier
// - refused supersede leaves old reservation intact
// - reserve conflicts only on clash with others or full table
// - zero descriptor count runs to last unit block
// - after reset clear, next command unit attention
`timescale 1ns/100ps
`default_nettype none
`include "erc_map.vh"
module erc_checker (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr
);
    localparam N = `ERC_SLOTS;

    reg [31:0] cmd_r;
    reg [31:0] desc0_r;
    reg [31:0] desc1_r;
    reg [31:0] acc_lo_r;
    reg [31:0] acc_cnt_r;
    reg [2:0]  status_r;
    reg        busy_r;
    reg [31:0] last_lba_r;
    reg        last_ok_r;
    reg [7:0]  ua_r;
    reg [7:0]  pset_map_r [0:7];

    reg        v_r   [0:N-1];
    reg [1:0]  ty_r  [0:N-1];
    reg [31:0] lo_r  [0:N-1];
    reg [31:0] hi_r  [0:N-1];
    reg [2:0]  own_r [0:N-1];
    reg [2:0]  mk_r  [0:N-1];
    reg        tp_r  [0:N-1];
    reg [7:0]  id_r  [0:N-1];

    wire wr_en = psel & penable & pwrite & clk_en;
    wire rd_ph = psel & penable & ~pwrite;
    wire mapped = (paddr <= `ERC_OFS_PSET) && (paddr[1:0] == 2'h0);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [3:0]  op    = cmd_r[`ERC_CMD_OP_LSB+3:`ERC_CMD_OP_LSB];
    wire [2:0]  ini   = cmd_r[`ERC_CMD_INIT_LSB+2:`ERC_CMD_INIT_LSB];
    wire        tpf   = cmd_r[`ERC_CMD_TPF_BIT];
    wire [2:0]  tpid  = cmd_r[`ERC_CMD_TPID_LSB+2:`ERC_CMD_TPID_LSB];
    wire [7:0]  rsvid = cmd_r[`ERC_CMD_RSV_LSB+7:`ERC_CMD_RSV_LSB];
    wire        link  = cmd_r[`ERC_CMD_LINK_BIT];
    wire [1:0]  dtype = desc0_r[`ERC_DESC_TYPE_LSB+1:`ERC_DESC_TYPE_LSB];
    wire        drel  = desc0_r[`ERC_DESC_REL_BIT];
    wire [23:0] dcnt  = desc0_r[31:8];

    // The owner that is granted the reservation.
    wire [2:0]  grant_own = tpf ? tpid : ini;
    wire [31:0] req_lo = drel ? last_lba_r + desc1_r : desc1_r;
    wire [31:0] req_hi = (dcnt == 24'h000000) ? `ERC_LAST_LBA :
                         req_lo + {8'h00, dcnt} - 32'h00000001;
    wire [31:0] acc_hi = (acc_cnt_r == 32'h00000000) ? acc_lo_r :
                         acc_lo_r + acc_cnt_r - 32'h00000001;
    wire        rel_bad = drel & ~(link & last_ok_r);

    reg        res_clash;
    reg        acc_block;
    reg        any_v;
    reg        sup_hit;
    reg [1:0]  sup_idx;
    reg        free_hit;
    reg [1:0]  free_idx;
    reg        ovl_r;
    reg        ovl_a;
    reg        other;
    integer    i;
    // Separate loop index for the clocked process, so that the two
    // processes never share a variable.
    integer    j;

    // Conflict matrix: an existing type against a requested type.
    function clash;
        input [1:0] held;
        input [1:0] req;
        begin
            case (held)
                `ERC_TYPE_RD_EXCL:   clash = (req != `ERC_TYPE_WR_EXCL);
                `ERC_TYPE_WR_EXCL:   clash = (req != `ERC_TYPE_RD_EXCL);
                `ERC_TYPE_EXCL:      clash = 1'b1;
                default:             clash = (req != `ERC_TYPE_RD_SHARED);
            endcase
        end
    endfunction

    always @* begin
        res_clash = 1'b0;
        acc_block = 1'b0;
        any_v     = 1'b0;
        sup_hit   = 1'b0;
        sup_idx   = 2'h0;
        free_hit  = 1'b0;
        free_idx  = 2'h0;
        ovl_r     = 1'b0;
        ovl_a     = 1'b0;
        other     = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            ovl_r = (req_lo <= hi_r[i]) && (lo_r[i] <= req_hi);
            ovl_a = (acc_lo_r <= hi_r[i]) && (lo_r[i] <= acc_hi);
            other = (own_r[i] != ini);
            if (v_r[i]) begin
                any_v = 1'b1;
                if (mk_r[i] == ini && id_r[i] == rsvid && !sup_hit) begin
                    sup_hit = 1'b1;
                    sup_idx = i[1:0];
                end
                // The slot being replaced never counts against the request.
                if (ovl_r && clash(ty_r[i], dtype) &&
                    !(sup_hit && sup_idx == i[1:0]) &&
                    (own_r[i] != grant_own)) begin
                    res_clash = 1'b1;
                end
                if (ovl_a) begin
                    case (ty_r[i])
                        `ERC_TYPE_EXCL:
                            acc_block = acc_block | other;
                        `ERC_TYPE_RD_EXCL:
                            acc_block = acc_block |
                                (other & op != `ERC_OP_WRITE);
                        `ERC_TYPE_WR_EXCL:
                            acc_block = acc_block |
                                (other & op != `ERC_OP_READ);
                        default:
                            acc_block = acc_block |
                                (op != `ERC_OP_READ);
                    endcase
                end
            end else if (!free_hit) begin
                free_hit = 1'b1;
                free_idx = i[1:0];
            end
        end
    end

    // A granted request lands in the replaced slot, else a free one.
    wire [1:0] tgt = sup_hit ? sup_idx : free_idx;
    wire       room = sup_hit | free_hit;
    wire       go_w = wr_en && paddr == `ERC_OFS_CMD &&
                      pwdata[`ERC_CMD_GO_BIT];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r      <= 32'h00000000;
            desc0_r    <= 32'h00000000;
            desc1_r    <= 32'h00000000;
            acc_lo_r   <= 32'h00000000;
            acc_cnt_r  <= 32'h00000000;
            status_r   <= `ERC_ST_GOOD;
            busy_r     <= 1'b0;
            last_lba_r <= 32'h00000000;
            last_ok_r  <= 1'b0;
            ua_r       <= 8'hff;
            for (j = 0; j < 8; j = j + 1) begin
                pset_map_r[j] <= j[7:0];
            end
            for (j = 0; j < N; j = j + 1) begin
                v_r[j]   <= 1'b0;
                ty_r[j]  <= 2'h0;
                lo_r[j]  <= 32'h00000000;
                hi_r[j]  <= 32'h00000000;
                own_r[j] <= 3'h0;
                mk_r[j]  <= 3'h0;
                tp_r[j]  <= 1'b0;
                id_r[j]  <= 8'h00;
            end
        end else if (clk_en) begin
            if (wr_en) begin
                case (paddr)
                    `ERC_OFS_CMD:    cmd_r     <= pwdata;
                    `ERC_OFS_DESC0:  desc0_r   <= pwdata;
                    `ERC_OFS_DESC1:  desc1_r   <= pwdata;
                    `ERC_OFS_ACC_LO: acc_lo_r  <= pwdata;
                    `ERC_OFS_ACC_CNT: acc_cnt_r <= pwdata;
                    default: ;
                endcase
            end
            busy_r <= go_w;
            if (busy_r) begin
                if (op == `ERC_OP_BDR) begin
                    ua_r <= 8'hff;
                    status_r <= `ERC_ST_GOOD;
                    for (j = 0; j < N; j = j + 1) begin
                        v_r[j] <= 1'b0;
                    end
                end else if (ua_r[ini]) begin
                    ua_r[ini] <= 1'b0;
                    status_r  <= `ERC_ST_UNIT_ATT;
                end else begin
                    case (op)
                        `ERC_OP_RESERVE: begin
                            if (rel_bad) begin
                                status_r <= `ERC_ST_ILLEGAL;
                            end else if (res_clash || !room) begin
                                status_r <= `ERC_ST_CONFLICT;
                            end else begin
                                status_r      <= `ERC_ST_GOOD;
                                v_r[tgt]      <= 1'b1;
                                ty_r[tgt]     <= dtype;
                                lo_r[tgt]     <= req_lo;
                                hi_r[tgt]     <= req_hi;
                                own_r[tgt]    <= grant_own;
                                mk_r[tgt]     <= ini;
                                tp_r[tgt]     <= tpf;
                                // Superseded slot keeps its old identifier.
                                id_r[tgt] <= sup_hit ? id_r[tgt] : rsvid;
                                if (tpf) begin
                                    pset_map_r[tpid] <= pset_map_r[ini];
                                end
                            end
                        end
                        `ERC_OP_RELEASE: begin
                            status_r <= `ERC_ST_GOOD;
                            for (j = 0; j < N; j = j + 1) begin
                                // On release, only the maker may drop a slot.
                                if (v_r[j] && mk_r[j] == ini &&
                                    id_r[j] == rsvid) begin
                                    v_r[j] <= 1'b0;
                                end
                            end
                        end
                        `ERC_OP_FORMAT:
                            status_r <= any_v ? `ERC_ST_CONFLICT
                                              : `ERC_ST_GOOD;
                        `ERC_OP_COPY:
                            status_r <= acc_block ? `ERC_ST_PROTECT
                                                  : `ERC_ST_GOOD;
                        default: begin
                            // Whole command refused, no partial effect.
                            status_r <= acc_block ? `ERC_ST_CONFLICT
                                                  : `ERC_ST_GOOD;
                            if (!acc_block) begin
                                last_lba_r <= acc_hi;
                                last_ok_r  <= link;
                            end
                        end
                    endcase
                end
            end
        end
    end

    always @* begin
        case (paddr)
            `ERC_OFS_CMD:      prdata = cmd_r;
            `ERC_OFS_DESC0:    prdata = desc0_r;
            `ERC_OFS_DESC1:    prdata = desc1_r;
            `ERC_OFS_ACC_LO:   prdata = acc_lo_r;
            `ERC_OFS_ACC_CNT:  prdata = acc_cnt_r;
            `ERC_OFS_STATUS:   prdata = {28'h0000000, busy_r, status_r};
            `ERC_OFS_LAST_LBA: prdata = last_lba_r;
            `ERC_OFS_UA:       prdata = {24'h000000, ua_r};
            `ERC_OFS_PSET:     prdata = {8'h00, 5'h00, pset_map_r[tpid],
                                         8'h00, 3'h0};
            default:           prdata = 32'h00000000;
        endcase
        if (!rd_ph) begin
            prdata = 32'h00000000;
        end
    end
endmodule // erc_checker
`default_nettype wire

// [core/erc_map.vh]
// Register offsets, field positions and codes of the extent reservation checker.
`ifndef ERC_MAP_VH
`define ERC_MAP_VH
`define ERC_OFS_CMD      12'h000
`define ERC_OFS_DESC0    12'h004
`define ERC_OFS_DESC1    12'h008
`define ERC_OFS_ACC_LO   12'h00c
`define ERC_OFS_ACC_CNT  12'h010
`define ERC_OFS_STATUS   12'h014
`define ERC_OFS_LAST_LBA 12'h018
`define ERC_OFS_UA       12'h01c
`define ERC_OFS_PSET     12'h020
// Command register fields.
`define ERC_CMD_OP_LSB   0
`define ERC_CMD_INIT_LSB 4
`define ERC_CMD_TPF_BIT  8
`define ERC_CMD_TPID_LSB 9
`define ERC_CMD_RSV_LSB  12
`define ERC_CMD_LINK_BIT 20
`define ERC_CMD_GO_BIT   31
// Descriptor byte 0 fields.
`define ERC_DESC_REL_BIT 2
`define ERC_DESC_TYPE_LSB 0
// Opcodes.
`define ERC_OP_RESERVE   4'h1
`define ERC_OP_READ      4'h2
`define ERC_OP_WRITE     4'h3
`define ERC_OP_COPY      4'h4
`define ERC_OP_FORMAT    4'h5
`define ERC_OP_RELEASE   4'h6
`define ERC_OP_BDR       4'h7
// Reservation types.
`define ERC_TYPE_RD_SHARED  2'h0
`define ERC_TYPE_WR_EXCL    2'h1
`define ERC_TYPE_RD_EXCL    2'h2
`define ERC_TYPE_EXCL       2'h3
// Completion status codes, slot count and last block address.
`define ERC_ST_GOOD      3'h0
`define ERC_ST_CONFLICT  3'h1
`define ERC_ST_ILLEGAL   3'h2
`define ERC_ST_PROTECT   3'h3
`define ERC_ST_UNIT_ATT  3'h4
`define ERC_SLOTS        4
`define ERC_LAST_LBA     32'h000fffff
`endif

// [tb/erc_apb_model.sv]
// Bus initiator model issuing register transfers to the checker.
`timescale 1ns/100ps
`default_nettype none
module erc_apb_model (
    input  wire         pclk,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr,
    output logic        hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        hung = 1'b0;
    end
    function automatic logic [31:0] d0(input logic [1:0] t, input logic r,
                                       input logic [23:0] c);
        return {c, 5'h0, r, t};
    endfunction
    // Request is held until pready is seen high, as the bus demands, or until 32 more edges pass.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 32) begin
            @(posedge pclk);
            n++;
        end
        if (n == 32) hung <= 1'b1;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-drives psel at once.
        @(posedge pclk);
    endtask
endmodule // erc_apb_model
`default_nettype wire

// [tb/erc_chk_checker.sv]
// Port assertions for the extent reservation checker.
`timescale 1ns/100ps
`default_nettype none
module erc_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        acc;
    logic        rd;
    logic        fresh_r;
    logic        st_ok_r;
    logic [31:0] st_r;
    assign acc = psel && penable;
    assign rd  = acc && !pwrite;
    // Any command write may change status, so the remembered copy is dropped.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fresh_r <= 1'b1;
            st_ok_r <= 1'b0;
            st_r    <= 32'h0;
        end else if (acc && pwrite && paddr == 12'h000) begin
            fresh_r <= 1'b0;
            st_ok_r <= 1'b0;
        end else if (rd && paddr == 12'h014 && !prdata[3]) begin
            st_ok_r <= 1'b1;
            st_r    <= prdata;
        end
    end
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    a_err_unmapped: assert property (acc && paddr > 12'h020
        |-> pslverr ##1 !pslverr) else $error("unmapped without error");
    a_err_mapped: assert property (acc && paddr <= 12'h020 &&
        paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped error");
    a_rdata_idle: assert property (!rd |-> prdata == 32'h0)
        else $error("read data outside read");
    a_rdata_unmapped: assert property (rd && paddr > 12'h020
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_ua_reset: assert property (
        rd && paddr == 12'h01c && fresh_r |-> prdata[7:0] == 8'hff)
        else $error("attention mask not full");
    a_status_holds: assert property (
        rd && paddr == 12'h014 && st_ok_r |-> prdata == st_r)
        else $error("status changed without command");
    c_conflict: cover property (rd && paddr == 12'h014 &&
        prdata[2:0] == 3'h1);
    c_unmapped: cover property (acc && pslverr);
    c_ua: cover property (rd && paddr == 12'h014 && prdata[2:0] == 3'h4);
endmodule // erc_chk
bind erc_checker erc_chk chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the extent reservation checker.
`timescale 1ns/100ps
`default_nettype none
`include "erc_map.vh"
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    wire         psel, penable, pwrite, pready, pslverr, hung;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    int          bad_count = 0, num_checks = 0, h, r, i, n;
    logic [31:0] q, lst, alo, acn;
    logic        e, tp_g = 1'b0, lk_g = 1'b0, en_g = 1'b1;
    logic [2:0]  tid_g = 3'h0;
    always #12.5 pclk = ~pclk;
    erc_checker dut_u (.pclk(pclk), .presetn(presetn), .clk_en(en_g),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    erc_apb_model ini_u (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ini_u.xfer(1'b1, a, d, q, e);
    endtask
    task automatic ex(input logic [1:0] t, input logic rl,
                      input logic [23:0] c, input logic [31:0] l);
        wr(12'h004, ini_u.d0(t, rl, c));
        wr(12'h008, l);
    endtask
    task automatic ac(input logic [31:0] l, input logic [31:0] c);
        alo = l;
        acn = c;
        wr(12'h00c, l);
        wr(12'h010, c);
    endtask
    function automatic logic cf(int a, int b);
        return (a == 3 || b == 3) ? 1'b1 : (a == 0 || b == 0) ? a != b :
            a == b;
    endfunction
    // Issue a command, wait for busy to drop and compare the status code.
    task automatic op(input logic [3:0] o, input logic [2:0] ini,
                      input logic [7:0] id, input logic [2:0] x);
        wr(12'h000, {1'b1, 10'h0, lk_g, id, tid_g, tp_g, 1'b0, ini, o});
        for (n = 0; n < 16; n++) begin
            ini_u.xfer(1'b0, 12'h014, 32'h0, q, e);
            if (q[3] === 1'b0) break;
        end
        if (n == 16) begin
            bad_count++;
            print_verdict;
        end
        chk({29'h0, q[2:0]}, {29'h0, x});
        if (x == 0 && (o == 2 || o == 3)) lst = alo + (acn ? acn - 1 : 0);
    endtask
    initial begin
        #(25 * 60000);
        bad_count++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h9bef));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ini_u.xfer(1'b0, 12'h01c, 32'h0, q, e);
        chk({24'h0, q[7:0]}, 32'hff);
        ac(32'd0, 32'd0);
        for (i = 0; i < 8; i++) op(2, i, 0, 4);
        for (h = 0; h < 4; h++) begin
            ex(h, 0, 24'd10, 32'd100);
            op(1, 0, 1, 0);
            for (r = 0; r < 4; r++) begin
                ex(r, 0, 24'd4, 32'd108);
                op(1, 1, 2, cf(h, r) ? 3'h1 : 3'h0);
                op(6, 1, 2, 0);
            end
            ac(32'd95 + h, 32'd10);
            op(2, 1, 0, h > 1 ? 3'h1 : 3'h0);
            op(3, 1, 0, h != 2 ? 3'h1 : 3'h0);
            op(3, 0, 0, h == 0 ? 3'h1 : 3'h0);
            ini_u.xfer(1'b0, 12'h018, 32'h0, q, e);
            chk(q, lst);
            if (h == 3) op(4, 1, 0, 3);
            if (h == 3) op(5, 2, 0, 1);
            op(6, 0, 1, 0);
        end
        $display("type table done");
        ex(3, 1, 24'd1, -32'sd10);
        op(1, 0, 3, 2);
        lk_g = 1'b1;
        ac(32'd300, 32'd0);
        op(2, 0, 0, 0);
        op(1, 0, 3, 0);
        lk_g = 1'b0;
        ac(lst - 10, 32'd0);
        op(2, 1, 0, 1);
        op(6, 0, 3, 0);
        ex(3, 0, 24'd0, 32'h000ffff0);
        op(1, 0, 9, 0);
        ac(`ERC_LAST_LBA, 32'd0);
        op(2, 1, 0, 1);
        op(6, 0, 9, 0);
        $display("relative and tail done");
        ex(3, 0, 24'd10, 32'd200);
        tp_g = 1'b1;
        tid_g = 3'd5;
        op(1, 2, 4, 0);
        tp_g = 1'b0;
        ini_u.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk({24'h0, q[18:11]}, 32'h2);
        ac(32'd200, 32'd0);
        op(2, 5, 0, 0);
        op(6, 1, 4, 0);
        op(2, 1, 0, 1);
        ex(3, 0, 24'd10, 32'd100);
        op(1, 0, 1, 0);
        ex(1, 0, 24'd10, 32'd300);
        op(1, 0, 1, 0);
        ac(32'd100, 32'd0);
        op(2, 1, 0, 0);
        ex(3, 0, 24'd10, 32'd200);
        op(1, 0, 1, 1);
        ac(32'd300, 32'd0);
        op(3, 1, 0, 1);
        ex(3, 0, 24'd10, 32'd305);
        op(1, 0, 1, 0);
        op(2, 1, 0, 0);
        op(6, 0, 1, 0);
        ac(32'd306, 32'd0);
        op(2, 1, 0, 0);
        op(7, 1, 0, 0);
        ac(32'd200, 32'd0);
        for (i = 0; i < 8; i++) op(2, i, 0, 4);
        op(2, 1, 0, 0);
        op(5, 2, 0, 0);
        $display("third party and supersede done");
        for (i = 0; i < 6; i++) begin
            ac(32'h00080000 | ($urandom % 32'h10000), $urandom % 8);
            op(2 + ($urandom % 2), $urandom % 8, 0, 0);
        end
        ini_u.xfer(1'b0, 12'h018, 32'h0, q, e);
        chk(q, lst);
        en_g <= 1'b0;
        wr(12'h00c, 32'h0000005a);
        en_g <= 1'b1;
        ini_u.xfer(1'b0, 12'h00c, 32'h0, q, e);
        chk(q, alo);
        ini_u.xfer(1'b0, 12'h040, 32'h0, q, e);
        chk({q[30:0], e}, 32'h1);
        chk({31'h0, hung}, 32'h0);
        $display("random and bus done");
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
